// ===== hw/kcfg_pkg.sv
// constants shared by the keypad configuration and analog scaling block
`default_nettype none
package kcfg_pkg;
	// *******************************************************
	// clock and time-out timing
	// *******************************************************
	localparam int CLK_HZ = 10_000_000;
	localparam int TICK_SEC = 1; // the time-out counts whole seconds
	localparam int TICK_CYCLES = CLK_HZ * TICK_SEC;

	// *******************************************************
	// register byte offsets
	// *******************************************************
	localparam logic [7:0] ADDR_FUNC = 8'h00;
	localparam logic [7:0] ADDR_VALUE = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_DISPLAY = 8'h0c;
	localparam logic [7:0] ADDR_POS = 8'h10;
	localparam logic [7:0] ADDR_LEVEL1 = 8'h14;
	localparam logic [7:0] ADDR_LEVEL2 = 8'h18;

	// status bit positions
	localparam int ST_PROG = 0;
	localparam int ST_SUPER = 1;
	localparam int ST_JUMPER = 2;
	localparam int ST_HEIGHT = 3;
	localparam int ST_ERR_LOCK = 4;
	localparam int ST_ERR_RANGE = 5;
	localparam int ST_ERR_FUNC = 6;
	localparam int ST_SIX = 7;

	// *******************************************************
	// function numbers and slot-relative offsets
	// *******************************************************
	localparam logic [9:0] FN_ACCESS = 10'h00a;
	localparam logic [9:0] FN_TIMEOUT = 10'h00b;
	localparam logic [9:0] FN_NEWCODE = 10'h05a;
	localparam int SLOT_STEP = 100;
	localparam logic [6:0] OFS_TYPE [2] = '{7'h04, 7'h0a};
	localparam logic [6:0] OFS_PMIN [2] = '{7'h02, 7'h08};
	localparam logic [6:0] OFS_PMAX [2] = '{7'h03, 7'h09};
	localparam logic [6:0] OFS_OMIN [2] = '{7'h05, 7'h0b};
	localparam logic [6:0] OFS_OMAX [2] = '{7'h06, 7'h0c};

	// *******************************************************
	// reset values and limits
	// *******************************************************
	localparam logic [23:0] CODE_RST = 24'h000834;
	localparam logic [23:0] CODE_MAX = 24'h0f423f;
	localparam logic [9:0] TMO_RST = 10'h078;
	localparam logic [9:0] TMO_MIN = 10'h00a;
	localparam logic [9:0] TMO_MAX = 10'h3e8;
	localparam logic signed [31:0] VOLT_MIN = 32'shffffd8f0;
	localparam logic signed [31:0] VOLT_MAX = 32'sh00002710;
	localparam logic signed [31:0] CUR_MIN = 32'sh00000000;
	localparam logic signed [31:0] CUR_MAX = 32'sh00004e20;

	typedef enum {CALC_IDLE, CALC_DIV, CALC_APPLY} calc_state_t;
endpackage
`default_nettype wire

// ===== hw/keypad_config_and_analog_scaling.sv
// keypad parameter interpreter with program modes and two scaled analog channels
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module keypad_config_and_analog_scaling #(
	parameter int SLOT = 2,
	parameter int POS_W = 24,
	parameter int CYC_PER_SEC = kcfg_pkg::TICK_CYCLES,
	parameter logic [23:0] SUPER_CODE = 24'h05a5a5 // arbitrary value
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [POS_W-1:0] position,
	input wire logic program_lockout_jumper,
	output logic prog_led,
	output logic [31:0] display,
	output logic display_six_digits,
	output logic signed [15:0] ch1_level,
	output logic signed [15:0] ch2_level,
	output logic ch1_current,
	output logic ch2_current
);
	localparam int NW = POS_W + 17;

	// *******************************************************
	// helper functions
	// *******************************************************
	// analog functions are slot digit times a hundred plus an offset
	function automatic logic [9:0] fn_code(input logic [6:0] ofs);
		return 10'(SLOT * kcfg_pkg::SLOT_STEP) + {3'h0, ofs};
	endfunction

	function automatic logic out_ok(input logic cur, input logic [31:0] v);
		logic signed [31:0] s;
		s = v;
		if (cur)
			return s >= kcfg_pkg::CUR_MIN && s <= kcfg_pkg::CUR_MAX;
		return s >= kcfg_pkg::VOLT_MIN && s <= kcfg_pkg::VOLT_MAX;
	endfunction

	function automatic logic is_mapped(input logic [7:0] a);
		return a[1:0] == 2'h0 && a <= kcfg_pkg::ADDR_LEVEL2;
	endfunction

	// *******************************************************
	// AXI4-Lite slave
	// *******************************************************
	logic aw_full_q, w_full_q, bvalid_q, rvalid_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q, rdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q, rresp_q;
	logic wr_fire, wr_ok, key_p, enter_p, func_p;
	logic [31:0] status, rd_mux;

	assign awready = !aw_full_q;
	assign wready = !w_full_q;
	assign arready = !rvalid_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	// address and data may arrive in either order; the write waits for both
	assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
	assign wr_ok = wr_fire && wstrb_q == 4'hf;
	assign func_p = wr_ok && awaddr_q == kcfg_pkg::ADDR_FUNC;
	assign enter_p = wr_ok && awaddr_q == kcfg_pkg::ADDR_VALUE;
	assign key_p = func_p || enter_p;

	// write address and data holding stages
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else begin
			if (awvalid && !aw_full_q) begin
				aw_full_q <= 1'b1;
				awaddr_q <= awaddr;
			end else if (wr_fire) begin
				aw_full_q <= 1'b0;
			end
			if (wvalid && !w_full_q) begin
				w_full_q <= 1'b1;
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end else if (wr_fire) begin
				w_full_q <= 1'b0;
			end
		end
	end

	// write response: partial strobes and unmapped words get SLVERR
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= 2'h0;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q <= (wr_ok && is_mapped(awaddr_q)) ? 2'h0 : 2'h2;
		end else if (bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// read channel, one cycle from address to data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= 2'h0;
		end else if (arvalid && !rvalid_q) begin
			rvalid_q <= 1'b1;
			rdata_q <= is_mapped(araddr) ? rd_mux : 32'h0000_0000;
			rresp_q <= is_mapped(araddr) ? 2'h0 : 2'h2;
		end else if (rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// *******************************************************
	// jumper synchroniser and function decode
	// *******************************************************
	logic jmp_meta_q, jmp_q;
	logic [9:0] fn_q;
	logic prog_q, super_q, show_height_q;
	logic [23:0] code_q;
	logic [9:0] tmo_q;
	logic [1:0] type_q;
	logic [POS_W-1:0] pmin_q [2];
	logic [POS_W-1:0] pmax_q [2];
	logic signed [15:0] omin_q [2];
	logic signed [15:0] omax_q [2];
	logic [1:0] hit_type, hit_pmin, hit_pmax, hit_omin, hit_omax;
	logic hit_acc, hit_tmo, hit_code, hit_param, val_ok;
	logic [31:0] cur_val;

	// the jumper is a pin; only the second stage is ever read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			jmp_meta_q <= 1'b0;
			jmp_q <= 1'b0;
		end else begin
			jmp_meta_q <= program_lockout_jumper;
			jmp_q <= jmp_meta_q;
		end
	end

	// decode the open function and check the entered value against it
	always_comb begin
		hit_acc = fn_q == kcfg_pkg::FN_ACCESS;
		hit_tmo = fn_q == kcfg_pkg::FN_TIMEOUT;
		hit_code = fn_q == kcfg_pkg::FN_NEWCODE;
		cur_val = 32'h0000_0000;
		val_ok = 1'b0;
		if (hit_tmo) begin
			cur_val = {22'h0, tmo_q};
			val_ok = wdata_q >= 32'(kcfg_pkg::TMO_MIN)
				&& wdata_q <= 32'(kcfg_pkg::TMO_MAX);
		end
		if (hit_code)
			val_ok = wdata_q <= 32'(kcfg_pkg::CODE_MAX);
		for (int c = 0; c < 2; c++) begin
			// only the board's own slot digit matches here
			hit_type[c] = fn_q == fn_code(kcfg_pkg::OFS_TYPE[c]);
			hit_pmin[c] = fn_q == fn_code(kcfg_pkg::OFS_PMIN[c]);
			hit_pmax[c] = fn_q == fn_code(kcfg_pkg::OFS_PMAX[c]);
			hit_omin[c] = fn_q == fn_code(kcfg_pkg::OFS_OMIN[c]);
			hit_omax[c] = fn_q == fn_code(kcfg_pkg::OFS_OMAX[c]);
			if (hit_type[c]) begin
				cur_val = {31'h0, type_q[c]};
				val_ok = wdata_q <= 32'h0000_0001;
			end
			if (hit_pmin[c] || hit_pmax[c]) begin
				cur_val = 32'(hit_pmin[c] ? pmin_q[c] : pmax_q[c]);
				val_ok = (wdata_q >> POS_W) == 32'h0000_0000;
			end
			if (hit_omin[c] || hit_omax[c]) begin
				cur_val = 32'(hit_omin[c] ? omin_q[c] : omax_q[c]);
				val_ok = out_ok(type_q[c], wdata_q);
			end
		end
		hit_param = hit_tmo || (|{hit_type, hit_pmin, hit_pmax, hit_omin,
			hit_omax});
	end

	// *******************************************************
	// program and supervisory modes
	// *******************************************************
	logic expire;

	// a key press in the expiry cycle wins, since it restarts the timer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prog_q <= 1'b0;
			super_q <= 1'b0;
		end else if (enter_p && hit_acc) begin
			if (jmp_q && wdata_q == {8'h00, code_q}) begin
				prog_q <= 1'b1;
				super_q <= 1'b0;
			end else if (jmp_q && wdata_q == {8'h00, SUPER_CODE}) begin
				prog_q <= 1'b1;
				super_q <= 1'b1;
			end else begin
				prog_q <= 1'b0;
				super_q <= 1'b0;
			end
		end else if (expire) begin
			prog_q <= 1'b0;
			super_q <= 1'b0;
		end
	end

	// access code changes only in supervisory mode
	always_ff @(posedge aclk) begin
		if (!aresetn)
			code_q <= kcfg_pkg::CODE_RST;
		else if (enter_p && hit_code && super_q && val_ok)
			code_q <= wdata_q[23:0];
	end

	assign prog_led = prog_q || super_q;

	// *******************************************************
	// parameter store
	// *******************************************************
	// writes outside program mode leave every parameter untouched
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tmo_q <= kcfg_pkg::TMO_RST;
			type_q <= 2'h0;
			for (int c = 0; c < 2; c++) begin
				pmin_q[c] <= '0;
				pmax_q[c] <= '0;
				omin_q[c] <= 16'sh0000;
				omax_q[c] <= 16'sh0000;
			end
		end else if (enter_p && prog_q && val_ok) begin
			if (hit_tmo)
				tmo_q <= wdata_q[9:0];
			for (int c = 0; c < 2; c++) begin
				if (hit_type[c])
					type_q[c] <= wdata_q[0];
				if (hit_pmin[c])
					pmin_q[c] <= wdata_q[POS_W-1:0];
				if (hit_pmax[c])
					pmax_q[c] <= wdata_q[POS_W-1:0];
				if (hit_omin[c])
					omin_q[c] <= wdata_q[15:0];
				if (hit_omax[c])
					omax_q[c] <= wdata_q[15:0];
			end
		end
	end

	// *******************************************************
	// error flags, open function and display
	// *******************************************************
	logic err_lock_q, err_range_q, err_func_q;
	logic valid_fn;

	assign valid_fn = hit_acc || hit_code || hit_param;

	// flags clear when a new function is opened, set on a refused entry
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			err_lock_q <= 1'b0;
			err_range_q <= 1'b0;
			err_func_q <= 1'b0;
		end else if (func_p) begin
			err_lock_q <= 1'b0;
			err_range_q <= 1'b0;
			err_func_q <= 1'b0;
		end else if (enter_p) begin
			err_func_q <= !valid_fn;
			err_lock_q <= (hit_param && !prog_q) || (hit_code && !super_q);
			err_range_q <= (hit_param || hit_code) && !val_ok;
		end
	end

	// opening a function leaves the shut-height view; expiry returns to it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fn_q <= 10'h000;
			show_height_q <= 1'b1;
		end else if (func_p) begin
			fn_q <= wdata_q[9:0];
			show_height_q <= 1'b0;
		end else if (expire) begin
			show_height_q <= 1'b1;
		end
	end

	// the access function always reads back as zero, never the code
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			display <= 32'h0000_0000;
			display_six_digits <= 1'b0;
		end else begin
			display <= show_height_q ? 32'(position) :
				(hit_acc ? 32'h0000_0000 : cur_val);
			display_six_digits <= !show_height_q && hit_acc && jmp_q;
		end
	end

	// *******************************************************
	// inactivity time-out
	// *******************************************************
	logic [31:0] sec_cnt_q;
	logic [10:0] tmo_cnt_q;
	logic tick, tmo_active;

	assign tick = sec_cnt_q == 32'(CYC_PER_SEC - 1);
	assign tmo_active = prog_q || super_q || !show_height_q;
	assign expire = tick && tmo_active && !key_p
		&& tmo_cnt_q + 11'h001 >= {1'b0, tmo_q};

	// one-second enable pulse
	always_ff @(posedge aclk) begin
		if (!aresetn)
			sec_cnt_q <= 32'h0000_0000;
		else if (tick || key_p)
			sec_cnt_q <= 32'h0000_0000;
		else
			sec_cnt_q <= sec_cnt_q + 32'h0000_0001;
	end

	// whole seconds since the last key press
	always_ff @(posedge aclk) begin
		if (!aresetn)
			tmo_cnt_q <= 11'h000;
		else if (key_p || expire || !tmo_active)
			tmo_cnt_q <= 11'h000;
		else if (tick)
			tmo_cnt_q <= tmo_cnt_q + 11'h001;
	end

	// *******************************************************
	// scaling engine, channels served in turn
	// *******************************************************
	kcfg_pkg::calc_state_t calc_q;
	logic ch_q, neg_q;
	logic [NW-1:0] quo_q;
	logic [POS_W:0] rem_q, rem_sh;
	logic [POS_W-1:0] den_q;
	logic [6:0] step_q;
	logic signed [15:0] base_q;
	logic signed [15:0] level_q [2];
	logic signed [16:0] diff;
	logic [16:0] span;
	logic signed [17:0] base_w, q_w;

	// a long serial divide keeps the datapath small; the update rate is
	// about one channel per position width plus nineteen cycles
	always_comb begin
		diff = 17'({omax_q[ch_q][15], omax_q[ch_q]})
			- 17'({omin_q[ch_q][15], omin_q[ch_q]});
		span = diff[16] ? 17'(-diff) : 17'(diff);
		rem_sh = {rem_q[POS_W-1:0], quo_q[NW-1]};
		base_w = 18'(base_q);
		q_w = 18'({1'b0, quo_q[16:0]});
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			calc_q <= kcfg_pkg::CALC_IDLE;
			ch_q <= 1'b0;
			neg_q <= 1'b0;
			quo_q <= '0;
			rem_q <= '0;
			den_q <= '0;
			step_q <= 7'h00;
			base_q <= 16'sh0000;
			level_q[0] <= 16'sh0000;
			level_q[1] <= 16'sh0000;
		end else begin
			unique case (calc_q)
				kcfg_pkg::CALC_IDLE: begin
					if (position <= pmin_q[ch_q]) begin
						level_q[ch_q] <= omin_q[ch_q];
						ch_q <= !ch_q;
					end else if (position >= pmax_q[ch_q]) begin
						level_q[ch_q] <= omax_q[ch_q];
						ch_q <= !ch_q;
					end else begin
						quo_q <= NW'(position - pmin_q[ch_q]) * NW'(span);
						den_q <= pmax_q[ch_q] - pmin_q[ch_q];
						rem_q <= '0;
						step_q <= 7'h00;
						neg_q <= diff[16];
						base_q <= omin_q[ch_q];
						calc_q <= kcfg_pkg::CALC_DIV;
					end
				end
				kcfg_pkg::CALC_DIV: begin
					if (rem_sh >= {1'b0, den_q}) begin
						rem_q <= rem_sh - {1'b0, den_q};
						quo_q <= {quo_q[NW-2:0], 1'b1};
					end else begin
						rem_q <= rem_sh;
						quo_q <= {quo_q[NW-2:0], 1'b0};
					end
					step_q <= step_q + 7'h01;
					if (step_q == 7'(NW - 1))
						calc_q <= kcfg_pkg::CALC_APPLY;
				end
				kcfg_pkg::CALC_APPLY: begin
					level_q[ch_q] <= 16'(neg_q ? base_w - q_w : base_w + q_w);
					ch_q <= !ch_q;
					calc_q <= kcfg_pkg::CALC_IDLE;
				end
			endcase
		end
	end

	assign ch1_level = level_q[0];
	assign ch2_level = level_q[1];
	assign ch1_current = type_q[0];
	assign ch2_current = type_q[1];

	// status word and read mux
	always_comb begin
		status = 32'h0000_0000;
		status[kcfg_pkg::ST_PROG] = prog_q;
		status[kcfg_pkg::ST_SUPER] = super_q;
		status[kcfg_pkg::ST_JUMPER] = jmp_q;
		status[kcfg_pkg::ST_HEIGHT] = show_height_q;
		status[kcfg_pkg::ST_ERR_LOCK] = err_lock_q;
		status[kcfg_pkg::ST_ERR_RANGE] = err_range_q;
		status[kcfg_pkg::ST_ERR_FUNC] = err_func_q;
		status[kcfg_pkg::ST_SIX] = display_six_digits;
		unique case (araddr)
			kcfg_pkg::ADDR_FUNC: rd_mux = {22'h0, fn_q};
			kcfg_pkg::ADDR_STATUS: rd_mux = status;
			kcfg_pkg::ADDR_DISPLAY: rd_mux = display;
			kcfg_pkg::ADDR_POS: rd_mux = 32'(position);
			kcfg_pkg::ADDR_LEVEL1: rd_mux = 32'(level_q[0]);
			kcfg_pkg::ADDR_LEVEL2: rd_mux = 32'(level_q[1]);
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// *******************************************************
	// assertions and covers
	// *******************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_lock_entry: assert property ($rose(prog_q) |-> jmp_q)
		else $error("program mode entered without jumper");
	a_led_follow: assert property (super_q |-> prog_led && prog_q)
		else $error("indicator off in supervisory mode");
	a_refuse_write: assert property (enter_p && !prog_q |=> $stable(tmo_q)
		&& $stable(type_q))
		else $error("parameter changed outside program mode");
	a_code_guard: assert property ($changed(code_q) |-> $past(super_q)
		&& $past(enter_p) && $past(hit_code))
		else $error("access code changed outside supervisory mode");
	a_bad_code: assert property (enter_p && hit_acc && wdata_q != 32'(code_q)
		&& wdata_q != 32'(SUPER_CODE) |=> !prog_q && !super_q)
		else $error("invalid code did not leave program mode");
	a_tmo_range: assert property (tmo_q >= kcfg_pkg::TMO_MIN
		&& tmo_q <= kcfg_pkg::TMO_MAX)
		else $error("time-out outside 10 to 1000 s");
	a_expire_home: assert property (expire |=> show_height_q && !prog_q
		&& tmo_cnt_q == 11'h000)
		else $error("expiry did not return to shut height");
	a_key_restart: assert property (key_p |=> tmo_cnt_q == 11'h000
		&& sec_cnt_q == 32'h0000_0000)
		else $error("key press did not restart the timer");
	a_clamp_low: assert property (calc_q == kcfg_pkg::CALC_IDLE && !ch_q
		&& position <= pmin_q[0] |=> ch1_level == $past(omin_q[0]))
		else $error("low clamp missed");
	a_interp_up: assert property (calc_q == kcfg_pkg::CALC_APPLY && !neg_q
		&& !ch_q |=> ch1_level >= $past(base_q))
		else $error("interpolated level below minimum output");

	c_prog_entry: cover property ($rose(prog_q));
	c_interp: cover property (calc_q == kcfg_pkg::CALC_APPLY);
	c_expire: cover property (expire && prog_q);
endmodule // keypad_config_and_analog_scaling
`default_nettype wire

// ===== tb/input_module_model.sv
// position source and lockout jumper standing at the far side of the block
`timescale 1ns/1ps
`default_nettype none
module input_module_model (
	input wire logic aclk,
	input wire logic [23:0] target,
	input wire logic jumper_in,
	output logic [23:0] position,
	output logic program_lockout_jumper
);
	// counts and jumper change only at a clock edge, as the input module does
	always_ff @(posedge aclk) begin
		position <= target;
		program_lockout_jumper <= jumper_in;
	end
endmodule // input_module_model
`default_nettype wire

// ===== tb/keypad_config_and_analog_scaling_tb.sv
// register-level bench for the keypad configuration and scaling block
`timescale 1ns/1ps
`default_nettype none
module keypad_config_and_analog_scaling_tb;
	localparam logic [23:0] SUP = 24'h05a5a5; // arbitrary value
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, jmp;
	logic awready, wready, bvalid, arready, rvalid, led, six, c1, c2;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, disp, rd_q;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, res_q;
	logic [23:0] target, position;
	logic jumper;
	logic signed [15:0] l1, l2;
	int miscompares = 0;
	int checks = 0;
	input_module_model PARTNER (.aclk(aclk), .target(target),
		.jumper_in(jmp), .position(position),
		.program_lockout_jumper(jumper));
	keypad_config_and_analog_scaling #(.SLOT(2), .POS_W(24), .CYC_PER_SEC(10),
		.SUPER_CODE(SUP)) DUT (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .position(position), .program_lockout_jumper(jumper),
		.prog_led(led), .display(disp), .display_six_digits(six),
		.ch1_level(l1), .ch2_level(l2), .ch1_current(c1), .ch2_current(c2));
	// *******************************************************
	// bus master and comparison tasks
	// *******************************************************
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// each channel released only at the edge that takes it; a write
		// that never answers is ended by the watchdog, not here
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid);
		res_q = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid);
		rd_q = rdata;
		res_q = rresp;
		rready <= 1'b0;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one function key press followed by an enter with a value
	task automatic key(input int fn, input logic [31:0] v);
		wr(kcfg_pkg::ADDR_FUNC, 32'(fn), 4'hf);
		wr(kcfg_pkg::ADDR_VALUE, v, 4'hf);
	endtask
	task automatic st(input int b, input logic e);
		rd(kcfg_pkg::ADDR_STATUS);
		chk("status bit", {31'h0, e}, {31'h0, rd_q[b]});
	endtask
	task automatic stop_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// *******************************************************
	// clock, reset and watchdog
	// *******************************************************
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	// the tests need little more than a thousand cycles; the margin covers slow answers
	initial begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		stop_test;
	end
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, jmp} = 6'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'h0;
		target = 24'h0000c8;
		aresetn = 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("led", 32'h0, {31'h0, led});
		rd(8'h40);
		chk("unmapped", 32'h2, {30'h0, res_q});
		wr(kcfg_pkg::ADDR_FUNC, 32'h0000000a, 4'h3);
		chk("strobe", 32'h2, {30'h0, res_q});
		key(204, 32'h0);
		st(kcfg_pkg::ST_ERR_LOCK, 1'b1);
		// jumper absent: one zero shown and no entry
		wr(kcfg_pkg::ADDR_FUNC, 32'h0000000a, 4'hf);
		// the six-zero flag is registered one edge behind the open function
		@(posedge aclk);
		chk("six", 32'h0, {31'h0, six});
		wr(kcfg_pkg::ADDR_VALUE, 32'h00000834, 4'hf);
		st(kcfg_pkg::ST_PROG, 1'b0);
		jmp <= 1'b1;
		repeat (4) @(posedge aclk);
		wr(kcfg_pkg::ADDR_FUNC, 32'h0000000a, 4'hf);
		@(posedge aclk);
		chk("six", 32'h1, {31'h0, six});
		wr(kcfg_pkg::ADDR_VALUE, 32'h00000834, 4'hf);
		chk("led", 32'h1, {31'h0, led});
		key(90, 32'h000004d2);
		st(kcfg_pkg::ST_ERR_LOCK, 1'b1);
		key(404, 32'h0);
		st(kcfg_pkg::ST_ERR_FUNC, 1'b1);
		// channel one: 2 to 8 V over 500 to 2000 counts
		key(204, 32'h0);
		key(202, 32'd500);
		key(205, 32'd2000);
		key(203, 32'd2000);
		key(206, 32'd8000);
		// channel two: current, 4 to 20 mA over 0 to 1000 counts
		key(210, 32'h1);
		key(211, 32'd25000);
		st(kcfg_pkg::ST_ERR_RANGE, 1'b1);
		key(208, 32'd0);
		key(211, 32'd4000);
		key(209, 32'd1000);
		key(212, 32'd20000);
		chk("type", 32'h1, {30'h0, c1, c2});
		target <= 24'd100;
		repeat (200) @(posedge aclk);
		chk("ch1", 32'd2000, {16'h0, l1});
		chk("ch2", 32'd5600, {16'h0, l2});
		target <= 24'd1250;
		repeat (200) @(posedge aclk);
		chk("ch1", 32'd5000, {16'h0, l1});
		chk("ch2", 32'd20000, {16'h0, l2});
		target <= 24'd3000;
		repeat (200) @(posedge aclk);
		chk("ch1", 32'd8000, {16'h0, l1});
		// supervisory entry, code change, old code then refused
		key(10, 32'(SUP));
		st(kcfg_pkg::ST_SUPER, 1'b1);
		key(90, 32'h000004d2);
		key(10, 32'h00000834);
		st(kcfg_pkg::ST_PROG, 1'b0);
		chk("led", 32'h0, {31'h0, led});
		key(10, 32'h000004d2);
		chk("led", 32'h1, {31'h0, led});
		key(11, 32'd5);
		st(kcfg_pkg::ST_ERR_RANGE, 1'b1);
		key(11, 32'd10);
		wr(kcfg_pkg::ADDR_FUNC, 32'h0000000b, 4'hf);
		// ten seconds of ten cycles; a key press here must hold it off
		repeat (80) @(posedge aclk);
		chk("led", 32'h1, {31'h0, led});
		wr(kcfg_pkg::ADDR_FUNC, 32'h0000000b, 4'hf);
		repeat (80) @(posedge aclk);
		chk("led", 32'h1, {31'h0, led});
		repeat (60) @(posedge aclk);
		chk("led", 32'h0, {31'h0, led});
		chk("display", {8'h0, position}, disp);
		stop_test;
	end
endmodule // keypad_config_and_analog_scaling_tb
`default_nettype wire
